// *** include/tsi_defs.svh ***
`ifndef TSI_DEFS_SVH
`define TSI_DEFS_SVH
`define TSI_CH_BITS 5
`define TSI_ST_BITS 2
`define TSI_SLOTS 128
`define TSI_UP_SRC 2
`define TSI_UP_OE 0
`define TSI_UP_MASK 8'h05
`define TSI_LO_ST_HI 6
`define TSI_LO_ST_LO 5
`define TSI_LO_CH_HI 4
`define TSI_BIT_CLKS 10
`endif

// *** include/tsi_pkg.sv ***
package tsi_pkg;
	typedef struct packed {
		logic we;
		logic upper;
		logic [6:0] addr;
		logic [7:0] wdata;
	} tsi_host_t;
	typedef struct packed {
		logic [3:0] data;
		logic [3:0] oe;
	} tsi_tx_t;
endpackage : tsi_pkg

// *** src/tsi_connection_memory.sv ***
`timescale 1ns/10ps
`include "tsi_defs.svh"
module tsi_connection_memory
	import tsi_pkg::*;
#(
	parameter int BIT_CLKS = `TSI_BIT_CLKS
)
(
	input wire logic CLK, // 40 MHz clock
	input wire logic RST_N, // sync reset, low
	input wire logic FRAME_START, // frame pulse, one cycle
	input wire logic [3:0] SERIAL_INPUT_STREAMS, // received bits
	input wire logic GLOBAL_OUTPUT_DRIVE, // high lets memory drive
	input wire logic PROCESSOR_MODE_FORCE, // control bit 6
	input wire tsi_host_t HOST, // host access
	output logic [7:0] HOST_RDATA, // read data
	output tsi_tx_t TX // serial outputs and enables
);
	// bdiv is eight bits wide, so a bit period cannot exceed 256 clocks
	generate
		if (BIT_CLKS < 2 || BIT_CLKS > 256)
		begin : g_bad_bit_clks
			$error("BIT_CLKS must lie between 2 and 256");
		end
	endgenerate
	typedef struct packed {
		logic [7:0] bdiv;
		logic [2:0] bitc;
		logic [4:0] slot;
		logic [3:0][7:0] rx_sh;
		logic [7:0] rd;
		logic [3:0] dout;
		logic [3:0] oe;
	} tsi_state_t;
	tsi_state_t s_r, s_nxt;
	logic [7:0] lower_mem [0:`TSI_SLOTS-1];
	logic [1:0] upper_mem [0:`TSI_SLOTS-1];
	logic [7:0] data_mem [0:`TSI_SLOTS-1];
	logic bit_tick, slot_end, load;
	logic [4:0] next_slot;
	logic [3:0] lane_d, lane_oe;
	logic [7:0] lane_byte [0:3];
	logic lane_drive [0:3];
	// ----------------------------------------------------------------
	// bit timing
	// ----------------------------------------------------------------
	assign bit_tick = (s_r.bdiv == 8'(BIT_CLKS - 1));
	assign slot_end = bit_tick && (s_r.bitc == 3'h7);
	assign load = FRAME_START || slot_end;
	assign next_slot = FRAME_START ? 5'h00 : s_r.slot + 5'h01;
	// ----------------------------------------------------------------
	// memories
	// ----------------------------------------------------------------
	always_ff @(posedge CLK)
	begin
		if (HOST.we && HOST.upper)
			upper_mem[HOST.addr] <= {HOST.wdata[`TSI_UP_SRC], HOST.wdata[`TSI_UP_OE]};
		if (HOST.we && !HOST.upper)
			lower_mem[HOST.addr] <= HOST.wdata;
		if (slot_end)
		begin
			for (int i = 0; i < 4; i++)
				data_mem[{2'(i), s_r.slot}] <= {s_r.rx_sh[i][6:0], SERIAL_INPUT_STREAMS[i]};
		end
	end
	// ----------------------------------------------------------------
	// per-lane source decode
	// ----------------------------------------------------------------
	always_comb
	begin
		for (int i = 0; i < 4; i++)
		begin
			logic [7:0] lo;
			logic [1:0] up;
			logic src, en;
			lo = lower_mem[{2'(i), next_slot}];
			up = upper_mem[{2'(i), next_slot}];
			src = up[1] || PROCESSOR_MODE_FORCE;
			en = up[0] || PROCESSOR_MODE_FORCE;
			if (src)
				lane_byte[i] = lo;
			else
				lane_byte[i] = data_mem[{lo[`TSI_LO_ST_HI:`TSI_LO_ST_LO], lo[`TSI_LO_CH_HI:0]}];
			lane_drive[i] = en && GLOBAL_OUTPUT_DRIVE;
		end
	end
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_lane
			tsi_shift u_lane (
				.clk(CLK),
				.rst_n(RST_N),
				.load(load),
				.shift(bit_tick),
				.byte_in(lane_byte[g]),
				.drive_in(lane_drive[g]),
				.dout(lane_d[g]),
				.oe(lane_oe[g])
			);
		end
	endgenerate
	// ----------------------------------------------------------------
	// state update
	// ----------------------------------------------------------------
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.bdiv = (bit_tick || FRAME_START) ? 8'h00 : s_r.bdiv + 8'h01;
		if (FRAME_START)
			s_nxt.bitc = 3'h0;
		else if (bit_tick)
			s_nxt.bitc = s_r.bitc + 3'h1;
		if (load)
			s_nxt.slot = next_slot;
		if (bit_tick)
		begin
			for (int i = 0; i < 4; i++)
				s_nxt.rx_sh[i] = {s_r.rx_sh[i][6:0], SERIAL_INPUT_STREAMS[i]};
		end
		if (HOST.upper)
			s_nxt.rd = {5'h00, upper_mem[HOST.addr][1], 1'b0, upper_mem[HOST.addr][0]} & `TSI_UP_MASK;
		else
			s_nxt.rd = lower_mem[HOST.addr];
		s_nxt.dout = lane_d;
		// floating is forced here too so the pin reacts within one cycle
		s_nxt.oe = GLOBAL_OUTPUT_DRIVE ? lane_oe : 4'h0;
	end
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end
	assign HOST_RDATA = s_r.rd;
	assign TX.data = s_r.dout;
	assign TX.oe = s_r.oe;
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_rd_upper;
		@(posedge CLK) disable iff (!RST_N) HOST.upper |=> (HOST_RDATA[7:3] == 5'h00);
	endproperty
	a_rd_upper: assert property (p_rd_upper) else $error("upper read nonzero high bits");
	property p_float;
		@(posedge CLK) disable iff (!RST_N) !GLOBAL_OUTPUT_DRIVE |=> (TX.oe == 4'h0);
	endproperty
	a_float: assert property (p_float) else $error("output driven while drive pin low");
	property p_drive_gate;
		@(posedge CLK) disable iff (!RST_N)
			(load && GLOBAL_OUTPUT_DRIVE && !PROCESSOR_MODE_FORCE && !upper_mem[{2'h2, next_slot}][0])
			|=> !lane_oe[2];
	endproperty
	a_drive_gate: assert property (p_drive_gate) else $error("lane enabled with drive bit clear");
	property p_oe_pin;
		@(posedge CLK) disable iff (!RST_N) (TX.oe != 4'h0) |-> $past(GLOBAL_OUTPUT_DRIVE);
	endproperty
	a_oe_pin: assert property (p_oe_pin) else $error("output driven without drive pin");
	property p_pmode_drive;
		@(posedge CLK) disable iff (!RST_N)
			(load && PROCESSOR_MODE_FORCE && GLOBAL_OUTPUT_DRIVE) |=> (lane_oe == 4'hF);
	endproperty
	a_pmode_drive: assert property (p_pmode_drive) else $error("processor mode not driving");
	property p_pmode_byte;
		@(posedge CLK) disable iff (!RST_N)
			PROCESSOR_MODE_FORCE |-> (lane_byte[0] == lower_mem[{2'h0, next_slot}]);
	endproperty
	a_pmode_byte: assert property (p_pmode_byte) else $error("processor mode byte wrong");
	property p_src_byte;
		@(posedge CLK) disable iff (!RST_N)
			upper_mem[{2'h1, next_slot}][1] |-> (lane_byte[1] == lower_mem[{2'h1, next_slot}]);
	endproperty
	a_src_byte: assert property (p_src_byte) else $error("constant byte not sent");
	property p_switch;
		@(posedge CLK) disable iff (!RST_N)
			(!PROCESSOR_MODE_FORCE && !upper_mem[{2'h1, next_slot}][1])
			|-> (lane_byte[1] == data_mem[{lower_mem[{2'h1, next_slot}][6:5], lower_mem[{2'h1, next_slot}][4:0]}]);
	endproperty
	a_switch: assert property (p_switch) else $error("switched byte wrong");
	property p_slot_len;
		@(posedge CLK) disable iff (!RST_N) (slot_end && !FRAME_START) |=> !slot_end [*8];
	endproperty
	a_slot_len: assert property (p_slot_len) else $error("slot too short");
	c_pmode: cover property (@(posedge CLK) PROCESSOR_MODE_FORCE && load);
	c_float: cover property (@(posedge CLK) $fell(GLOBAL_OUTPUT_DRIVE));
	c_wrap: cover property (@(posedge CLK) slot_end && s_r.slot == 5'h1F);
endmodule : tsi_connection_memory

// *** src/tsi_shift.sv ***
`timescale 1ns/10ps
`include "tsi_defs.svh"
// one serial output lane: loads a byte and drive flag per slot, shifts msb first
module tsi_shift
	import tsi_pkg::*;
(
	input wire logic clk, // clock
	input wire logic rst_n, // sync reset
	input wire logic load, // slot start
	input wire logic shift, // bit strobe
	input wire logic [7:0] byte_in, // slot byte
	input wire logic drive_in, // slot drive
	output logic dout, // serial bit
	output logic oe // drive enable
);
	typedef struct packed {
		logic [7:0] sh;
		logic oe;
	} tsi_sh_state_t;
	tsi_sh_state_t s_r, s_nxt;
	always_comb
	begin
		s_nxt = s_r;
		if (load)
		begin
			s_nxt.sh = byte_in;
			s_nxt.oe = drive_in;
		end
		else if (shift)
			s_nxt.sh = {s_r.sh[6:0], 1'b0};
	end
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end
	assign dout = s_r.sh[7];
	assign oe = s_r.oe;
endmodule : tsi_shift

// *** verification/test_tsi_connection_memory.sv ***
`timescale 1ns/10ps
module test_tsi_connection_memory
	import tsi_pkg::*;
;
	localparam int BC = 2;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic frame_start = 1'b0;
	logic drive = 1'b0;
	logic pmf = 1'b0;
	logic [3:0] rx;
	tsi_host_t host = '0;
	logic [7:0] host_rdata;
	tsi_tx_t tx;
	int fc = 0;
	int n_fail = 0;
	int n_compared = 0;
	logic [7:0] d;
	logic [7:0] ov;
	tsi_connection_memory #(.BIT_CLKS(BC)) dut (.CLK(clk), .RST_N(rst_n), .FRAME_START(frame_start),
		.SERIAL_INPUT_STREAMS(rx), .GLOBAL_OUTPUT_DRIVE(drive), .PROCESSOR_MODE_FORCE(pmf),
		.HOST(host), .HOST_RDATA(host_rdata), .TX(tx));
	tsi_serial_src #(.BIT_CLKS(BC)) src (.clk(clk), .frame_start(frame_start), .rx(rx));
	always #12.5 clk = ~clk;
	// frame counter: equals the edge number within the frame at each rising edge
	always @(negedge clk)
	begin
		fc <= (fc + 1) % (256 * BC);
		frame_start <= ((fc + 1) % (256 * BC) == 0);
	end
	task chk8(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk8
	task wr(input logic up, input logic [6:0] a, input logic [7:0] v);
		@(negedge clk);
		host <= '{1'b1, up, a, v};
		@(negedge clk);
		host.we <= 1'b0;
	endtask : wr
	task rd(input logic up, input logic [6:0] a, output logic [7:0] v);
		@(negedge clk);
		host <= '{1'b0, up, a, 8'h00};
		@(negedge clk);
		v = host_rdata;
	endtask : rd
	// samples each bit in the last of the two cycles in which it stands on the pin
	task cap(input int lane, input int slot, output logic [7:0] b, output logic [7:0] e);
		for (int k = 0; k < 8; k++)
		begin
			do @(posedge clk); while (fc != slot * 8 * BC + 2 + k * BC);
			#1;
			b[7 - k] = tx.data[lane];
			e[7 - k] = tx.oe[lane];
		end
	endtask : cap
	task close_out;
		if (n_fail == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : close_out
	initial
	begin
		#400000;
		n_fail++;
		close_out();
	end
	initial
	begin
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		// memories power up unknown: program every location, lower half first, outputs left floating
		for (int a = 0; a < 128; a++)
			wr(1'b0, 7'(a), 8'h00);
		for (int a = 0; a < 128; a++)
			wr(1'b1, 7'(a), 8'h04);
		wr(1'b1, 7'd3, 8'hFF);
		rd(1'b1, 7'd3, d);
		chk8(d, 8'h05);
		wr(1'b0, 7'd3, 8'h9C);
		cap(0, 3, d, ov);
		chk8(ov, 8'h00);
		@(negedge clk);
		drive = 1'b1;
		cap(0, 3, d, ov);
		chk8(d, 8'h9C);
		chk8(ov, 8'hFF);
		wr(1'b1, 7'd36, 8'h01);
		for (int s = 0; s < 4; s++)
		begin
			wr(1'b0, 7'd36, {1'b1, 2'(s), 5'(31 - s)});
			cap(1, 4, d, ov);
			chk8(d, 8'(s * 32 + 31 - s) ^ 8'h3C);
		end
		wr(1'b1, 7'd64, 8'h04);
		wr(1'b0, 7'd64, 8'h5A);
		cap(2, 0, d, ov);
		chk8(ov, 8'h00);
		wr(1'b1, 7'd103, 8'h00);
		wr(1'b0, 7'd103, 8'hC1);
		@(negedge clk);
		pmf = 1'b1;
		cap(2, 0, d, ov);
		chk8(d, 8'h5A);
		chk8(ov, 8'hFF);
		cap(3, 7, d, ov);
		chk8(d, 8'hC1);
		@(negedge clk);
		drive = 1'b0;
		cap(3, 7, d, ov);
		chk8(ov, 8'h00);
		close_out();
	end
endmodule : test_tsi_connection_memory

// *** verification/tsi_serial_src.sv ***
`timescale 1ns/10ps
// far-end serial source: each lane sends a fixed byte per slot, msb first
module tsi_serial_src
	import tsi_pkg::*;
#(
	parameter int BIT_CLKS = 2
)
(
	input wire logic clk, // clock
	input wire logic frame_start, // frame pulse
	output logic [3:0] rx // serial input streams
);
	int cnt_r;
	int cur;
	int pos;
	function automatic logic [7:0] pat(input int s, input int c);
		return 8'(s * 32 + c) ^ 8'h3C;
	endfunction : pat
	always_comb cur = frame_start ? 0 : cnt_r;
	always_ff @(posedge clk) cnt_r <= cur + 1;
	// the switch starts its first bit period one clock after the frame edge, so the pattern trails by one
	always_comb pos = (cur + 256 * BIT_CLKS - 1) % (256 * BIT_CLKS);
	// bit held for a whole period so the sample point inside it never matters
	always_comb
	begin : drive_lanes
		logic [7:0] b;
		b = 8'h00;
		for (int s = 0; s < 4; s++)
		begin
			b = pat(s, (pos / (8 * BIT_CLKS)) % 32);
			rx[s] = b[7 - (pos / BIT_CLKS) % 8];
		end
	end
endmodule : tsi_serial_src
